// ===== src/prot_frame_pkg.sv
// Purpose: Constants shared by the protection frame and its register file
// Assumes: AXI4-Lite slave, 32-bit data, one word per register
// Notes: Offsets are byte addresses
package prot_frame_pkg;
    localparam int unsigned num_elements = 8;
    localparam int unsigned num_phases = 3;
    localparam int unsigned num_breakers = 2;
    localparam int unsigned addr_width = 8;

    localparam logic [7:0] ctrl_offset = 8'h00;
    localparam logic [7:0] superv_offset = 8'h04;
    localparam logic [7:0] onep_offset = 8'h08;
    localparam logic [7:0] dirmode_offset = 8'h0c;
    localparam logic [7:0] dirwant_offset = 8'h10;
    localparam logic [7:0] cmdblk_offset = 8'h14;
    localparam logic [7:0] route_offset = 8'h18;
    localparam logic [7:0] status_offset = 8'h20;
    localparam logic [7:0] irq_status_offset = 8'h24;
    localparam logic [7:0] irq_mask_offset = 8'h28;
    localparam logic [7:0] alarm_view_offset = 8'h2c;
    localparam logic [7:0] trip_view_offset = 8'h30;

    // Control register fields
    localparam int unsigned ctrl_func_bit = 0;
    localparam int unsigned ctrl_ext_block_allow_bit = 1;
    localparam int unsigned ctrl_trip_block_perm_bit = 2;
    localparam int unsigned ctrl_ext_trip_allow_bit = 3;
    localparam logic [31:0] ctrl_reset = 32'h0000_0001;

    // Interrupt status fields
    localparam int unsigned irq_alarm_bit = 0;
    localparam int unsigned irq_trip_bit = 1;
    localparam int unsigned irq_cmd_bit = 2;
    localparam int unsigned irq_width = 3;

    // Direction result encodings
    localparam logic [1:0] dir_none = 2'h0;
    localparam logic [1:0] dir_forward = 2'h1;
    localparam logic [1:0] dir_reverse = 2'h2;
    localparam logic [1:0] dir_not_possible = 2'h3;

    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// ===== src/prot_frame.sv
// Purpose: Master protection frame collecting element alarms and trips
// Assumes: Element decisions arrive synchronous to aclk
// Notes: Element alarm/trip timing lives in the elements themselves
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
module prot_frame #(
    parameter int unsigned n_el = prot_frame_pkg::num_elements,
    parameter int unsigned n_br = prot_frame_pkg::num_breakers
) (
    input wire logic aclk, // System clock, 10 MHz
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [n_el-1:0] elem_alarm, // Element alarms
    input wire logic [n_el-1:0] elem_trip, // Element timed trips
    input wire logic [n_el*3-1:0] elem_phase, // Phases each element flags
    input wire logic [1:0] dir_raw, // Raw direction decision
    input wire logic phasor_ok, // Phasors large enough
    input wire logic ext_block_in_a, // External protection block A
    input wire logic ext_block_in_b, // External protection block B
    input wire logic ext_trip_block_in, // External trip-command block
    output logic general_alarm, // Collective alarm
    output logic general_trip, // Collective trip
    output logic [2:0] phase_collective_alarm, // Per-phase alarms
    output logic [2:0] phase_collective_trip, // Per-phase trips
    output logic [n_el-1:0] trip_command_out, // Element trip commands
    output logic [n_br-1:0] breaker_trip, // Per-breaker trip
    output logic [1:0] dir_result, // Reported direction
    output logic irq, // Level interrupt
    input wire logic [7:0] s_axi_awaddr, // AXI write address
    input wire logic s_axi_awvalid, // AXI write address valid
    output logic s_axi_awready, // AXI write address ready
    input wire logic [31:0] s_axi_wdata, // AXI write data
    input wire logic [3:0] s_axi_wstrb, // AXI write strobes
    input wire logic s_axi_wvalid, // AXI write data valid
    output logic s_axi_wready, // AXI write data ready
    output logic [1:0] s_axi_bresp, // AXI write response
    output logic s_axi_bvalid, // AXI write response valid
    input wire logic s_axi_bready, // AXI write response ready
    input wire logic [7:0] s_axi_araddr, // AXI read address
    input wire logic s_axi_arvalid, // AXI read address valid
    output logic s_axi_arready, // AXI read address ready
    output logic [31:0] s_axi_rdata, // AXI read data
    output logic [1:0] s_axi_rresp, // AXI read response
    output logic s_axi_rvalid, // AXI read valid
    input wire logic s_axi_rready // AXI read ready
);
    ////////////////////////////////////////////////////////////////////////
    logic [31:0] ctrl;
    logic [n_el-1:0] superv_only;
    logic [n_el-1:0] single_phase;
    logic [n_el-1:0] dir_mode;
    logic [2*n_el-1:0] dir_want;
    logic [n_el-1:0] cmd_block;
    logic [n_el*n_br-1:0] route;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [n_el-1:0] alarm_view;
    logic [n_el-1:0] trip_view;

    logic prot_block;
    logic cmd_suppress;
    logic [1:0] next_dir;
    logic [n_el-1:0] fwd;
    logic [n_el-1:0] fwd_alarm;
    logic [n_el-1:0] fwd_trip;
    logic [n_el-1:0] next_cmd;
    logic next_galarm;
    logic next_gtrip;
    logic [2:0] next_palarm;
    logic [2:0] next_ptrip;
    logic [n_br-1:0] next_brk;

    function automatic logic [31:0] widen(input logic [n_el-1:0] v);
        widen = 32'h0;
        widen[n_el-1:0] = v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Blocking, evaluated combinationally so a block bites this cycle
    always_comb begin
        prot_block = !ctrl[prot_frame_pkg::ctrl_func_bit];
        if (ctrl[prot_frame_pkg::ctrl_ext_block_allow_bit] &&
            (ext_block_in_a || ext_block_in_b)) begin
            prot_block = 1'b1;
        end
        cmd_suppress = prot_block ||
            ctrl[prot_frame_pkg::ctrl_trip_block_perm_bit];
        if (ctrl[prot_frame_pkg::ctrl_ext_trip_allow_bit] &&
            ext_trip_block_in) begin
            cmd_suppress = 1'b1;
        end
    end

    // Direction report; too-small phasors override the raw decision
    always_comb begin
        next_dir = phasor_ok ? dir_raw :
            prot_frame_pkg::dir_not_possible;
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-element gating
    genvar g;
    generate
        for (g = 0; g < n_el; g++) begin : el
            logic dir_ok;
            // Alarm and timed trip come from the element itself
            assign dir_ok = !dir_mode[g] ||
                (next_dir == dir_want[2*g+1:2*g]);
            assign fwd[g] = !superv_only[g] && !prot_block;
            assign fwd_alarm[g] = fwd[g] && elem_alarm[g];
            assign fwd_trip[g] = fwd[g] && elem_trip[g] && dir_ok;
            assign next_cmd[g] = fwd_trip[g] && !cmd_block[g] &&
                !cmd_suppress;
        end
    endgenerate

    always_comb begin
        next_galarm = |fwd_alarm;
        next_gtrip = |fwd_trip;
        next_palarm = 3'h0;
        next_ptrip = 3'h0;
        for (int i = 0; i < n_el; i++) begin
            if (single_phase[i]) begin
                next_palarm = next_palarm |
                    ({3{fwd_alarm[i]}} & elem_phase[3*i+:3]);
                next_ptrip = next_ptrip |
                    ({3{fwd_trip[i]}} & elem_phase[3*i+:3]);
            end
        end
        for (int b = 0; b < n_br; b++) begin
            next_brk[b] = |(next_cmd & route[b*n_el+:n_el]);
        end
    end

    // Outputs registered; the block still masks decisions in its own cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            general_alarm <= 1'b0;
            general_trip <= 1'b0;
            phase_collective_alarm <= 3'h0;
            phase_collective_trip <= 3'h0;
            trip_command_out <= '0;
            breaker_trip <= '0;
            dir_result <= prot_frame_pkg::dir_none;
        end else begin
            general_alarm <= next_galarm;
            general_trip <= next_gtrip;
            phase_collective_alarm <= next_palarm;
            phase_collective_trip <= next_ptrip;
            trip_command_out <= next_cmd;
            breaker_trip <= next_brk;
            dir_result <= next_dir;
        end
    end

    // Local element states stay visible even for supervision-only elements
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alarm_view <= '0;
            trip_view <= '0;
        end else begin
            alarm_view <= elem_alarm;
            trip_view <= elem_trip;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path: address and data may come in either order
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic [31:0] wmask;
    logic [2:0] w1c;

    assign do_write = aw_held && w_held && !s_axi_bvalid;
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            wmask[8*k+:8] = {8{w_strb[k]}};
        end
    end
    assign w1c = (do_write && aw_addr == prot_frame_pkg::irq_status_offset)
        ? (w_data[2:0] & wmask[2:0]) : 3'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= prot_frame_pkg::resp_okay;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr > prot_frame_pkg::route_offset &&
                    aw_addr != prot_frame_pkg::irq_status_offset &&
                    aw_addr != prot_frame_pkg::irq_mask_offset) ?
                    prot_frame_pkg::resp_slverr : prot_frame_pkg::resp_okay;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= prot_frame_pkg::ctrl_reset;
            superv_only <= '0;
            single_phase <= '0;
            dir_mode <= '0;
            dir_want <= '0;
            cmd_block <= '0;
            route <= '1;
            irq_mask <= 3'h0;
        end else if (do_write) begin
            case (aw_addr)
                prot_frame_pkg::ctrl_offset:
                    ctrl <= (ctrl & ~wmask) | (w_data & wmask & 32'hf);
                prot_frame_pkg::superv_offset:
                    superv_only <= w_data[n_el-1:0];
                prot_frame_pkg::onep_offset:
                    single_phase <= w_data[n_el-1:0];
                prot_frame_pkg::dirmode_offset:
                    dir_mode <= w_data[n_el-1:0];
                prot_frame_pkg::dirwant_offset:
                    dir_want <= w_data[2*n_el-1:0];
                prot_frame_pkg::cmdblk_offset:
                    cmd_block <= w_data[n_el-1:0];
                prot_frame_pkg::route_offset:
                    route <= w_data[n_el*n_br-1:0];
                prot_frame_pkg::irq_mask_offset:
                    irq_mask <= w_data[2:0];
                default: ;
            endcase
        end
    end

    // Sticky events; a new event in the clearing cycle survives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= 3'h0;
            irq <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~w1c) |
                {|next_cmd, next_gtrip, next_galarm};
            irq <= |(irq_status & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path, answer one cycle after the address is taken
    logic [31:0] rd_word;
    always_comb begin
        case (s_axi_araddr)
            prot_frame_pkg::ctrl_offset: rd_word = ctrl & 32'hf;
            prot_frame_pkg::superv_offset: rd_word = widen(superv_only);
            prot_frame_pkg::onep_offset: rd_word = widen(single_phase);
            prot_frame_pkg::dirmode_offset: rd_word = widen(dir_mode);
            prot_frame_pkg::dirwant_offset: rd_word = 32'(dir_want);
            prot_frame_pkg::cmdblk_offset: rd_word = widen(cmd_block);
            prot_frame_pkg::route_offset: rd_word = 32'(route);
            prot_frame_pkg::status_offset:
                rd_word = {22'h0, dir_result, prot_block, cmd_suppress,
                    phase_collective_trip, phase_collective_alarm};
            prot_frame_pkg::irq_status_offset: rd_word = {29'h0, irq_status};
            prot_frame_pkg::irq_mask_offset: rd_word = {29'h0, irq_mask};
            prot_frame_pkg::alarm_view_offset: rd_word = widen(alarm_view);
            prot_frame_pkg::trip_view_offset: rd_word = widen(trip_view);
            default: rd_word = 32'h0;
        endcase
    end

    logic rd_bad;
    assign rd_bad = s_axi_araddr > prot_frame_pkg::trip_view_offset ||
        s_axi_araddr[1:0] != 2'h0 ||
        (s_axi_araddr > prot_frame_pkg::route_offset &&
         s_axi_araddr < prot_frame_pkg::status_offset);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= prot_frame_pkg::resp_okay;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_bad ? 32'h0 : rd_word;
                s_axi_rresp <= rd_bad ? prot_frame_pkg::resp_slverr :
                    prot_frame_pkg::resp_okay;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_block_kills_all:
    assert property (@(posedge aclk) disable iff (!aresetn)
        prot_block |=> !general_alarm && !general_trip &&
        trip_command_out == 0)
        else $error("output active while protection blocked");
    a_ext_block_in:
    assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl[prot_frame_pkg::ctrl_ext_block_allow_bit] &&
        (ext_block_in_a || ext_block_in_b) |=> !general_trip)
        else $error("external block ignored");
    a_perm_cmd_block:
    assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl[prot_frame_pkg::ctrl_trip_block_perm_bit] |=>
        trip_command_out == 0)
        else $error("command despite permanent block");
    a_ext_cmd_block:
    assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl[prot_frame_pkg::ctrl_ext_trip_allow_bit] && ext_trip_block_in
        |=> breaker_trip == 0 && trip_command_out == 0)
        else $error("breaker trip despite external block");
    a_superv_only:
    assert property (@(posedge aclk) disable iff (!aresetn)
        (elem_alarm & ~superv_only) == 0 |=> !general_alarm)
        else $error("supervision element raised general alarm");
    a_general_alarm:
    assert property (@(posedge aclk) disable iff (!aresetn)
        !prot_block && |(elem_alarm & ~superv_only) |=> general_alarm)
        else $error("general alarm missing");
    a_cmd_needs_trip:
    assert property (@(posedge aclk) disable iff (!aresetn)
        trip_command_out != 0 |-> general_trip)
        else $error("command without general trip");
    a_dir_report:
    assert property (@(posedge aclk) disable iff (!aresetn)
        !phasor_ok |=> dir_result == prot_frame_pkg::dir_not_possible)
        else $error("direction not flagged as not possible");
    a_block_release:
    assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(prot_block) && ctrl[prot_frame_pkg::ctrl_func_bit] &&
        |(elem_alarm & ~superv_only) |=> general_alarm)
        else $error("alarm not released after block");
    a_breaker_from_cmd:
    assert property (@(posedge aclk) disable iff (!aresetn)
        breaker_trip != 0 |-> trip_command_out != 0)
        else $error("breaker trip without trip command");
    a_phase_alarm_src:
    assert property (@(posedge aclk) disable iff (!aresetn)
        phase_collective_alarm != 0 |-> general_alarm)
        else $error("phase alarm without general alarm");
endmodule

// ===== tb/elem_model.sv
// Purpose: Behavioural protective elements feeding the protection frame
// Assumes: Fault criteria arrive as levels from the bench
// Notes: Trip delay is shortened to keep the run brief
`timescale 1ns/1ns
module elem_model #(
    parameter int unsigned n_el = 8,
    parameter int unsigned delay = 3
) (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [n_el-1:0] fault, // Fault criterion per element
    output logic [n_el-1:0] elem_alarm, // Element alarms
    output logic [n_el-1:0] elem_trip // Element timed trips
);
    int cnt [n_el];

    ////////////////////////////////////////////////////////////////////////
    always @(posedge aclk) begin
        for (int i = 0; i < n_el; i++) begin
            if (!aresetn || !fault[i]) begin
                cnt[i] <= 0;
                elem_alarm[i] <= 1'b0;
                elem_trip[i] <= 1'b0;
            end else begin
                elem_alarm[i] <= 1'b1;
                if (cnt[i] < delay)
                    cnt[i] <= cnt[i] + 1;
                // Criterion must persist for the whole delay
                elem_trip[i] <= (cnt[i] >= delay - 1);
            end
        end
    end
endmodule

// ===== tb/tb_protection_alarm_trip_aggregator.sv
// Purpose: Self-checking bench for the protection frame
// Assumes: Register writes land well before the settle window ends
// Notes: Reference model recomputes every output except irq and the AXI signals each cycle
`timescale 1ns/1ns
`define check(got, exp) begin compares++; if ((got) !== (exp)) begin fails++; \
    $display("unexpected at %0t: output mismatch", $time); end end
module tb_protection_alarm_trip_aggregator;
    logic aclk = 0, aresetn = 0, phasor_ok = 1, chk = 0;
    logic ext_block_in_a = 0, ext_block_in_b = 0, ext_trip_block_in = 0;
    logic [7:0] fault = 0, c_sup, c_onep, c_dm, c_cb, e_cmd;
    logic [23:0] elem_phase = 0;
    logic [1:0] dir_raw = 0, dir_result, e_dir, rr;
    logic [15:0] c_dw, c_route;
    logic [3:0] c_ctrl;
    logic [2:0] pa, pt, e_pa, e_pt;
    logic [7:0] elem_alarm, elem_trip, cmd;
    logic [1:0] br, e_br, bresp, rresp;
    logic ga, gt, irq, e_ga, e_gt, blk, sup, tr;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    int fails = 0, compares = 0, seed = 67;

    always #50 aclk = ~aclk;

    elem_model #(.n_el(8), .delay(3)) i_elem_model (.aclk(aclk),
        .aresetn(aresetn), .fault(fault), .elem_alarm(elem_alarm),
        .elem_trip(elem_trip));
    prot_frame #(.n_el(8), .n_br(2)) i_prot_frame (.aclk(aclk),
        .aresetn(aresetn), .elem_alarm(elem_alarm), .elem_trip(elem_trip),
        .elem_phase(elem_phase), .dir_raw(dir_raw), .phasor_ok(phasor_ok),
        .ext_block_in_a(ext_block_in_a), .ext_block_in_b(ext_block_in_b),
        .ext_trip_block_in(ext_trip_block_in), .general_alarm(ga),
        .general_trip(gt), .phase_collective_alarm(pa),
        .phase_collective_trip(pt), .trip_command_out(cmd),
        .breaker_trip(br), .dir_result(dir_result), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    ////////////////////////////////////////////////////////////////////////
    // Reference model: sees inputs as sampled at the edge
    always @(posedge aclk) begin
        blk = !c_ctrl[0] || (c_ctrl[1] && (ext_block_in_a || ext_block_in_b));
        sup = c_ctrl[2] || (c_ctrl[3] && ext_trip_block_in);
        e_dir = phasor_ok ? dir_raw : prot_frame_pkg::dir_not_possible;
        {e_ga, e_gt, e_pa, e_pt, e_cmd} = '0;
        for (int i = 0; i < 8; i++) begin
            tr = elem_trip[i] && !c_sup[i] &&
                (!c_dm[i] || c_dw[2*i+:2] == e_dir);
            e_ga |= elem_alarm[i] && !c_sup[i];
            e_gt |= tr;
            e_cmd[i] = tr && !c_cb[i] && !sup;
            for (int p = 0; p < 3; p++) begin
                if (c_onep[i] && elem_phase[3*i+p]) begin
                    e_pa[p] |= elem_alarm[i] && !c_sup[i];
                    e_pt[p] |= tr;
                end
            end
        end
        if (blk)
            {e_ga, e_gt, e_pa, e_pt, e_cmd} = '0;
        for (int b = 0; b < 2; b++)
            e_br[b] = |(e_cmd & c_route[8*b+:8]);
    end

    always @(negedge aclk) begin
        if (chk) begin
            `check(ga, e_ga)
            `check(gt, e_gt)
            `check(pa, e_pa)
            `check(pt, e_pt)
            `check(cmd, e_cmd)
            `check(br, e_br)
            `check(dir_result, e_dir)
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
                          input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // Loop until bvalid; the watchdog ends a hung wait
        do begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        `check(bresp, er)
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        rready <= 1'b0;
        `check(rresp, er)
    endtask

    task automatic apply(input logic [3:0] c, input logic [7:0] sv, op, dm,
        input logic [15:0] dw, input logic [7:0] cb, input logic [15:0] rt,
        input logic [1:0] dr, input logic pk);
        chk = 0;
        {c_ctrl, c_sup, c_onep, c_dm, c_dw, c_cb, c_route} =
            {c, sv, op, dm, dw, cb, rt};
        axi_wr(prot_frame_pkg::ctrl_offset, {28'h0, c}, 2'h0);
        axi_wr(prot_frame_pkg::superv_offset, {24'h0, sv}, 2'h0);
        axi_wr(prot_frame_pkg::onep_offset, {24'h0, op}, 2'h0);
        axi_wr(prot_frame_pkg::dirmode_offset, {24'h0, dm}, 2'h0);
        axi_wr(prot_frame_pkg::dirwant_offset, {16'h0, dw}, 2'h0);
        axi_wr(prot_frame_pkg::cmdblk_offset, {24'h0, cb}, 2'h0);
        axi_wr(prot_frame_pkg::route_offset, {16'h0, rt}, 2'h0);
        dir_raw <= dr;
        phasor_ok <= pk;
        repeat (3) @(posedge aclk);
        chk = 1;
        // Faults toggle rarely so delayed trips get a chance to form
        repeat (250) begin
            @(posedge aclk);
            fault <= fault ^ 8'($random(seed) & $random(seed) & $random(seed));
            elem_phase <= 24'($random(seed));
            ext_block_in_a <= ($random(seed) & 15) == 0;
            ext_block_in_b <= ($random(seed) & 15) == 0;
            ext_trip_block_in <= ($random(seed) & 7) == 0;
        end
        chk = 0;
        // Let the last random values stand one edge before clearing
        @(posedge aclk);
        {fault, ext_block_in_a, ext_block_in_b, ext_trip_block_in} <= '0;
    endtask

    task automatic wrap_up;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge aclk);
        fails++;
        wrap_up;
    end

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(prot_frame_pkg::ctrl_offset, 2'h0);
        `check(d, prot_frame_pkg::ctrl_reset)
        axi_rd(prot_frame_pkg::route_offset, 2'h0);
        `check(d[15:0], 16'hffff)
        axi_rd(8'h1c, prot_frame_pkg::resp_slverr);
        `check(d, 32'h0)
        axi_wr(8'h1c, 32'hffff_ffff, prot_frame_pkg::resp_slverr);
        apply(4'h1, 8'h00, 8'hff, 8'h00, 16'h0, 8'h00, 16'hffff, 2'h1, 1'b1);
        apply(4'h0, 8'h00, 8'hff, 8'h00, 16'h0, 8'h00, 16'hffff, 2'h1, 1'b1);
        apply(4'h3, 8'h00, 8'hff, 8'h00, 16'h0, 8'h00, 16'hffff, 2'h1, 1'b1);
        apply(4'h5, 8'h00, 8'hff, 8'h00, 16'h0, 8'h00, 16'hffff, 2'h1, 1'b1);
        apply(4'h9, 8'h00, 8'hff, 8'h00, 16'h0, 8'h00, 16'hffff, 2'h1, 1'b1);
        apply(4'h1, 8'ha5, 8'h3c, 8'h00, 16'h0, 8'h11, 16'h3cc3, 2'h1, 1'b1);
        for (int k = 1; k < 4; k++)
            apply(4'h1, 8'h00, 8'hff, 8'hf0, 16'h69a5, 8'h00, 16'hffff,
                  2'(k), k < 3);
        apply(4'h1, 8'h00, 8'hff, 8'h00, 16'h0, 8'h00, 16'hffff, 2'h1, 1'b1);
        // Element 1 supervises only: visible locally; element 0 still raises events
        axi_wr(prot_frame_pkg::superv_offset, 32'h2, 2'h0);
        axi_wr(prot_frame_pkg::irq_status_offset, 32'h7, 2'h0);
        @(posedge aclk);
        fault <= 8'h03;
        repeat (10) @(posedge aclk);
        axi_rd(prot_frame_pkg::irq_status_offset, 2'h0);
        `check(d, 32'h7)
        `check(irq, 1'b0)
        axi_rd(prot_frame_pkg::alarm_view_offset, 2'h0);
        `check(d, 32'h3)
        axi_rd(prot_frame_pkg::trip_view_offset, 2'h0);
        `check(d, 32'h3)
        axi_wr(prot_frame_pkg::irq_mask_offset, 32'h2, 2'h0);
        repeat (3) @(posedge aclk);
        `check(irq, 1'b1)
        fault <= 8'h00;
        repeat (5) @(posedge aclk);
        axi_wr(prot_frame_pkg::irq_status_offset, 32'h7, 2'h0);
        repeat (3) @(posedge aclk);
        axi_rd(prot_frame_pkg::irq_status_offset, 2'h0);
        `check(d, 32'h0)
        `check(irq, 1'b0)
        wrap_up;
    end
endmodule
